/* inc/psagg_params.svh */
// constants for the status aggregation block: command codes, bit positions
// assumes a command decoder upstream presents one decoded access per cycle
// What this block does
// - writes to read-only codes raise invalid-command fault
// - fault sets communication summary bit in status byte
// - fault sets invalid-command flag, bit 7, status cml
// - fault notifies host by asserting alert line
// - aggregate status write leaves status bits unchanged
// - phase FFh or 80h returns per-phase fault map
// - other phase returns bit 0 any-status-set
// - unassigned or disabled phase bits read zero
// - bits 3..0 flag faults of phases 3..0
`ifndef PSAGG_PARAMS_SVH
`define PSAGG_PARAMS_SVH
`define PSAGG_CMD_AGGREGATE  8'hDB
`define PSAGG_CMD_PHASE_SUM  8'hDC
`define PSAGG_PHASE_ALL      8'hFF
`define PSAGG_PHASE_ALL_ALT  8'h80
`define PSAGG_BYTE_CML_BIT   1
`define PSAGG_CML_IVC_BIT    7
`define PSAGG_NUM_PHASES     4
`endif

/* inc/psagg_pkg.sv */
// types for the status aggregation block
// assumes the params header is on the include path
package psagg_pkg;
   typedef logic [7:0]  psagg_byte_t;
   typedef logic [55:0] psagg_agg_t;
   typedef logic [15:0] psagg_word_t;
endpackage : psagg_pkg

/* rtl/psagg_status.sv */
// status aggregation: aggregate readback, per-phase summary, invalid-write fault
// assumes the command decoder gives cmd_code with a one-cycle write or read strobe
`timescale 1ns/100ps
`include "psagg_params.svh"
module psagg_status #(
   parameter int NPH = `PSAGG_NUM_PHASES
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // decoded command access
   input  wire logic [7:0]         cmd_code,
   input  wire logic               cmd_wr,
   input  wire logic               cmd_rd,
   input  wire logic               cmd_is_ro,
   input  wire logic [7:0]         phase_sel,
   // live status bytes
   input  wire psagg_pkg::psagg_byte_t st_mfr,
   input  wire psagg_pkg::psagg_byte_t st_other,
   input  wire psagg_pkg::psagg_byte_t st_cml,
   input  wire psagg_pkg::psagg_byte_t st_temp,
   input  wire psagg_pkg::psagg_byte_t st_input,
   input  wire psagg_pkg::psagg_byte_t st_iout,
   input  wire psagg_pkg::psagg_byte_t st_vout,
   // per-phase fault state and assignment
   input  wire logic [NPH-1:0]     phase_fault,
   input  wire logic [NPH-1:0]     phase_enabled,
   input  wire logic               active_any_status,
   // fault reporting outputs
   output logic                    ivc_set,
   output logic                    byte_cml_set,
   output logic                    alert_n,
   // read data
   output psagg_pkg::psagg_agg_t   agg_rdata,
   output psagg_pkg::psagg_word_t  phase_rdata,
   output logic                    rd_valid
);
   import psagg_pkg::*;

   // ========================================
   // local sizes and constants
   // ========================================

   // summary word width, fixed by the command format
   localparam int WORD_W = 16;
   // aggregate readback width, seven status bytes
   localparam int AGG_W  = 56;
   // number of always-zero bits above the phase map
   localparam int PAD_W  = WORD_W - NPH;

   // command codes and phase selectors at their bus widths
   localparam logic [7:0] CODE_AGG = `PSAGG_CMD_AGGREGATE;
   localparam logic [7:0] CODE_SUM = `PSAGG_CMD_PHASE_SUM;
   localparam logic [7:0] SEL_ALL  = `PSAGG_PHASE_ALL;
   localparam logic [7:0] SEL_ALT  = `PSAGG_PHASE_ALL_ALT;

   // ========================================
   // access decode
   // ========================================

   // the access addresses the aggregate readback
   wire logic hit_agg;
   // the access addresses the per-phase summary
   wire logic hit_sum;
   // a read of the aggregate readback
   wire logic rd_agg;
   // a read of the per-phase summary
   wire logic rd_sum;
   // a write that the command set refuses
   wire logic bad_wr;

   assign hit_agg = (cmd_code == CODE_AGG);
   assign hit_sum = (cmd_code == CODE_SUM);
   assign rd_agg  = cmd_rd & hit_agg;
   assign rd_sum  = cmd_rd & hit_sum;

   // the aggregate code counts as read-only even if the decoder misses it
   assign bad_wr  = cmd_wr & (cmd_is_ro | hit_agg);

   // ========================================
   // phase selection
   // ========================================

   // broadcast selector: the host asks for the whole map
   wire logic sel_all;
   // alternate broadcast selector, treated the same way
   wire logic sel_alt;
   // either selector picks the map form of the summary
   wire logic all_phase;

   assign sel_all   = (phase_sel == SEL_ALL);
   assign sel_alt   = (phase_sel == SEL_ALT);
   assign all_phase = sel_all | sel_alt;

   // ========================================
   // per-phase fault map
   // ========================================

   // one bit per phase, forced low for unassigned or disabled phases
   wire logic [NPH-1:0] map;

   genvar gi;
   generate
      for (gi = 0; gi < NPH; gi++)
      begin : g_phase
         // a phase only reports while it is assigned and enabled
         assign map[gi] = phase_fault[gi] & phase_enabled[gi];
      end
   endgenerate

   // map padded to the word, reserved bits held at zero
   wire psagg_word_t map_word;
   assign map_word = {{PAD_W{1'b0}}, map};

   // named flags of the four phase positions
   wire logic phase_zero_fault_flag;
   wire logic phase_one_fault_flag;
   wire logic phase_two_fault_flag;
   wire logic phase_three_fault_flag;

   assign phase_zero_fault_flag  = map_word[0];
   assign phase_one_fault_flag   = map_word[1];
   assign phase_two_fault_flag   = map_word[2];
   assign phase_three_fault_flag = map_word[3];

   // ========================================
   // summary and readback next values
   // ========================================

   // single-phase form: bit 0 tells whether the selected phase shows any status
   wire psagg_word_t one_word;
   assign one_word = {15'h0000, active_any_status};

   // map form rebuilt from the named flags
   wire psagg_word_t all_word;
   assign all_word = {map_word[WORD_W-1:4], phase_three_fault_flag, phase_two_fault_flag,
                      phase_one_fault_flag, phase_zero_fault_flag};

   // summary value chosen by the phase selector
   wire psagg_word_t phase_d;
   assign phase_d = all_phase ? all_word : one_word;

   // live status bytes packed manufacturer byte first
   wire psagg_agg_t agg_d;
   assign agg_d = {st_mfr, st_other, st_cml, st_temp,
                   st_input, st_iout, st_vout};

   // ========================================
   // fault reporting registers
   // ========================================

   logic ivc_q;   // invalid-command set request, one cycle
   logic cml_q;   // communication summary set request, one cycle
   logic alert_q; // host notification, held until reset

   // set request to the invalid-command flag of the communication status
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ivc_q <= 1'b0;
      end
      else
      begin
         ivc_q <= bad_wr;
      end
   end

   // set request to the communication summary bit of the status byte
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cml_q <= 1'b0;
      end
      else
      begin
         cml_q <= bad_wr;
      end
   end

   // notification stays up until reset; clearing belongs to the alert responder
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alert_q <= 1'b0;
      end
      else
      begin
         alert_q <= alert_q | bad_wr;
      end
   end

   // ========================================
   // read data registers
   // ========================================

   psagg_agg_t  agg_q;   // aggregate readback
   psagg_word_t phase_q; // per-phase summary
   logic        valid_q; // read answer strobe

   // aggregate readback captured on its read, never on a write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         agg_q <= 56'h0;
      end
      else if (rd_agg)
      begin
         agg_q <= agg_d;
      end
   end

   // summary captured on its read, never on a write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_q <= 16'h0000;
      end
      else if (rd_sum)
      begin
         phase_q <= phase_d;
      end
   end

   // one-cycle strobe marking the read answer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         valid_q <= 1'b0;
      end
      else
      begin
         valid_q <= cmd_rd;
      end
   end

   // ========================================
   // outputs
   // ========================================

   // one-cycle set requests toward the status bytes
   assign ivc_set      = ivc_q;
   assign byte_cml_set = cml_q;

   // notification is active low on the pin
   assign alert_n      = ~alert_q;

   // read data and its strobe straight from the flops
   assign agg_rdata    = agg_q;
   assign phase_rdata  = phase_q;
   assign rd_valid     = valid_q;

   // ========================================
   // checks
   // ========================================

   // a refused write raises the invalid-command request and the alert
   ivc_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      bad_wr |=> ivc_set && !alert_n)
      else $error("ivc missed");

   // a refused write raises the communication summary request
   cml_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      bad_wr |=> byte_cml_set)
      else $error("cml summary missed");

   // the alert never drops before reset
   alert_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !alert_n |=> !alert_n)
      else $error("alert dropped");

   // no fault without a refused write
   quiet_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !bad_wr |=> !ivc_set && !byte_cml_set)
      else $error("spurious fault");

   // reserved summary bits stay low
   reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      phase_rdata[15:4] == 12'h000)
      else $error("reserved set");

   // map read returns the enabled faulted phases
   map_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rd_sum && all_phase) |=> phase_rdata == {{PAD_W{1'b0}}, $past(phase_fault & phase_enabled)})
      else $error("map read wrong");

   // single-phase read returns the any-status bit
   one_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rd_sum && !all_phase) |=> phase_rdata == {15'h0000, $past(active_any_status)})
      else $error("phase read wrong");

   // aggregate read packs the bytes in order
   agg_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_agg |=> agg_rdata == $past({st_mfr, st_other, st_cml, st_temp, st_input, st_iout, st_vout}))
      else $error("aggregate read wrong");

   // a write alone leaves both readbacks as they were
   write_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmd_wr && !cmd_rd) |=> $stable(agg_rdata) && $stable(phase_rdata))
      else $error("readback changed by write");

   // every read is answered next cycle
   read_valid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_rd |=> rd_valid)
      else $error("read not answered");
endmodule : psagg_status

/* sim/psagg_host.sv */
// far-side model: live status bytes of the stacked device
// assumes the bench owns clock and accesses
`timescale 1ns/100ps
module psagg_host (
   // status bytes, manufacturer byte highest
   output psagg_pkg::psagg_agg_t st_all
);
   import psagg_pkg::*;
   // distinct pattern per byte exposes any swap
   assign st_all = 56'hA1B2C3D4E5F607;
endmodule : psagg_host

/* sim/test_pmbus_status_aggregation.sv */
// bench: decoded command accesses with expected read data and fault pulses
// assumes params header and package are compiled first
`timescale 1ns/100ps
module test_pmbus_status_aggregation;
   import psagg_pkg::*;
   logic       core_clk = 0, rst_n = 0, wr = 0, rd = 0, any = 0, ro = 1;
   logic [7:0] code = 8'h00, ph = 8'h00;
   logic       ivc, cml, al_n, vld;
   psagg_agg_t st, agg;
   psagg_word_t pw;
   int         failures = 0, compares = 0, cyc = 0;
   always #2 core_clk = ~core_clk;
   psagg_host host_u (.st_all(st));
   psagg_status dut_u (.core_clk(core_clk), .rst_n(rst_n), .cmd_code(code), .cmd_wr(wr),
      .cmd_rd(rd), .cmd_is_ro(ro), .phase_sel(ph), .st_mfr(st[55:48]),
      .st_other(st[47:40]), .st_cml(st[39:32]), .st_temp(st[31:24]),
      .st_input(st[23:16]), .st_iout(st[15:8]), .st_vout(st[7:0]), .phase_fault(4'hF),
      .phase_enabled(4'h5), .active_any_status(any), .ivc_set(ivc), .byte_cml_set(cml),
      .alert_n(al_n), .agg_rdata(agg), .phase_rdata(pw), .rd_valid(vld));
   task chk(input logic [55:0] seen, input logic [55:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one strobe cycle, then sample the registered answer
   task acc(input logic [7:0] c, input logic w, input logic [7:0] p, input logic a);
      @(posedge core_clk);
      code <= c;
      wr   <= w;
      rd   <= !w;
      ph   <= p;
      any  <= a;
      @(posedge core_clk);
      wr   <= 1'b0;
      rd   <= 1'b0;
      #1;
   endtask : acc
   task end_of_test;
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         failures++;
         end_of_test();
      end
   end
   // main sequence
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      acc(8'hDB, 1'b0, 8'h00, 1'b0);
      chk(agg, st, "aggregate");
      chk({vld, al_n, ivc}, 3'b110, "read flags");
      ro <= 1'b0;
      acc(8'h20, 1'b1, 8'h00, 1'b0);
      chk({ivc, cml, al_n}, 3'b001, "writable code");
      ro <= 1'b1;
      acc(8'hDB, 1'b1, 8'h00, 1'b0);
      chk({ivc, cml, al_n}, 3'b110, "fault");
      acc(8'hDB, 1'b0, 8'hFF, 1'b0);
      chk(agg, st, "aggregate after write");
      acc(8'hDC, 1'b0, 8'hFF, 1'b0);
      chk(pw, 16'h0005, "map all");
      acc(8'hDC, 1'b0, 8'h80, 1'b0);
      chk(pw, 16'h0005, "map alt");
      acc(8'hDC, 1'b0, 8'h02, 1'b1);
      chk(pw, 16'h0001, "one phase");
      acc(8'hDC, 1'b0, 8'h01, 1'b0);
      chk(pw, 16'h0000, "one phase idle");
      chk(al_n, 1'b0, "alert held");
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk({al_n, ivc, vld, pw}, {3'b100, 16'h0000}, "after reset");
      acc(8'hDC, 1'b0, 8'h80, 1'b0);
      chk(pw, 16'h0005, "map after reset");
      end_of_test();
   end
endmodule : test_pmbus_status_aggregation
